// file: hw/pwrseq_pkg.sv
// Package for the power-on/off sequencer: timing constants and states
package pwrseq_pkg;
	localparam longint unsigned PWRSEQ_CLK_HZ = 64'd100000000;
	localparam longint unsigned PWRSEQ_ACT_S = 64'd50;
	localparam longint unsigned PWRSEQ_ACT_CYC = PWRSEQ_ACT_S * PWRSEQ_CLK_HZ;
	localparam longint unsigned PWRSEQ_FIN_MS = 64'd40;
	localparam longint unsigned PWRSEQ_FIN_CYC = PWRSEQ_FIN_MS * PWRSEQ_CLK_HZ / 64'd1000;
	localparam int PWRSEQ_CNT_W = 33;
	localparam logic PWRSEQ_REQ_RST = 1'b0;

	typedef enum logic [3:0] {
		PWRSEQ_OFF = 4'h1,
		PWRSEQ_INIT = 4'h2,
		PWRSEQ_ACTIVE = 4'h4,
		PWRSEQ_FINAL = 4'h8
	} pwrseq_state_e;
endpackage

// file: hw/pwrseq_if.sv
// Interface carrying the power sequencing pins between host and module
interface pwrseq_if;
	logic power_off_req_n;
	logic system_reset_in_n;
	logic ref_supply_out;
	logic boot_ok;
	logic fast_shutdown_trig;
	modport module_end (input power_off_req_n, system_reset_in_n, fast_shutdown_trig,
		output ref_supply_out, boot_ok);
	modport host_end (output power_off_req_n, system_reset_in_n, fast_shutdown_trig,
		input ref_supply_out, boot_ok);
endinterface

// file: hw/pwrseq_module.sv
// Module end: power-on initialisation, activation and shutdown sequencing
module pwrseq_module
	import pwrseq_pkg::*;
#(
	parameter longint unsigned ACT_CYC = PWRSEQ_ACT_CYC,
	parameter longint unsigned FIN_CYC = PWRSEQ_FIN_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	pwrseq_if.module_end pins,
	input wire logic shutdown_indication_enable,
	input wire logic fast_shutdown_enable,
	output logic cmd_port_ready,
	output logic fully_active,
	output logic [3:0] state_out
);
	pwrseq_state_e state_r, state_nxt;
	logic [PWRSEQ_CNT_W-1:0] cnt_r, cnt_nxt;
	logic trig_d_r, restart_block_r, restart_block_nxt;
	logic ref_r, boot_r, cmd_r;

	wire cnt_act_done = cnt_r >= PWRSEQ_CNT_W'(ACT_CYC - 64'd1);
	wire cnt_fin_done = cnt_r >= PWRSEQ_CNT_W'(FIN_CYC - 64'd1);
	// Only a configured line with a real high-to-low edge counts
	wire trig_fall = fast_shutdown_enable & trig_d_r & ~pins.fast_shutdown_trig;
	wire sys_reset = ~pins.system_reset_in_n;
	wire req_on = pins.power_off_req_n;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + PWRSEQ_CNT_W'(1);
		restart_block_nxt = restart_block_r & req_on;
		unique case (state_r)
			PWRSEQ_OFF: begin
				cnt_nxt = '0;
				// After fast shutdown the request must drop before a restart
				if (req_on && !restart_block_r && !sys_reset) begin
					state_nxt = PWRSEQ_INIT;
				end
			end
			PWRSEQ_INIT: begin
				if (!req_on || trig_fall) begin
					state_nxt = PWRSEQ_FINAL;
					cnt_nxt = '0;
				end else if (cnt_act_done) begin
					state_nxt = PWRSEQ_ACTIVE;
				end
			end
			PWRSEQ_ACTIVE: begin
				cnt_nxt = '0;
				if (!req_on || trig_fall) begin
					state_nxt = PWRSEQ_FINAL;
				end
			end
			PWRSEQ_FINAL: begin
				if (cnt_fin_done) begin
					state_nxt = PWRSEQ_OFF;
					cnt_nxt = '0;
					restart_block_nxt = req_on;
				end
			end
		endcase
		// Emergency reset drops straight to off, no finalization
		if (sys_reset) begin
			state_nxt = PWRSEQ_OFF;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= PWRSEQ_OFF;
			cnt_r <= '0;
			trig_d_r <= 1'b0;
			restart_block_r <= 1'b0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			trig_d_r <= pins.fast_shutdown_trig;
			restart_block_r <= restart_block_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ref_r <= 1'b0;
			boot_r <= 1'b0;
			cmd_r <= 1'b0;
		end else if (clk_en) begin
			ref_r <= state_nxt != PWRSEQ_OFF;
			boot_r <= shutdown_indication_enable && state_nxt == PWRSEQ_ACTIVE;
			cmd_r <= state_nxt == PWRSEQ_INIT || state_nxt == PWRSEQ_ACTIVE;
		end
	end

	assign pins.ref_supply_out = ref_r;
	assign pins.boot_ok = boot_r;
	assign cmd_port_ready = cmd_r;
	assign fully_active = state_r == PWRSEQ_ACTIVE;
	assign state_out = state_r;
endmodule

// file: hw/pwrseq_host.sv
// Host end: drives power request, reset and fast shutdown trigger
module pwrseq_host
	import pwrseq_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	pwrseq_if.host_end pins,
	input wire logic power_on_cmd,
	input wire logic fast_off_cmd,
	input wire logic use_boot_ok,
	output logic module_ready,
	output logic module_off,
	output logic power_remove_ok
);
	logic req_r, trig_r, seen_on_r, ready_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_r <= PWRSEQ_REQ_RST;
			trig_r <= 1'b1;
			seen_on_r <= 1'b0;
			ready_r <= 1'b0;
		end else if (clk_en) begin
			req_r <= power_on_cmd;
			trig_r <= ~fast_off_cmd;
			seen_on_r <= pins.ref_supply_out;
			// Talk only after boot-complete; never ready while the indication is not in use
			ready_r <= pins.ref_supply_out && use_boot_ok && pins.boot_ok;
		end
	end

	assign pins.power_off_req_n = req_r;
	assign pins.system_reset_in_n = 1'b1;
	// Trigger idles high only while the module is powered
	assign pins.fast_shutdown_trig = trig_r & pins.ref_supply_out;
	assign module_ready = ready_r;
	assign module_off = ~pins.ref_supply_out;
	assign power_remove_ok = seen_on_r & ~pins.ref_supply_out | ~req_r & ~pins.ref_supply_out;
endmodule

// file: tb/pwrseq_monitor.sv
// Checker on the power sequencing pins between host and module
module pwrseq_monitor #(
	parameter int ACT = 20
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic power_off_req_n,
	input wire logic system_reset_in_n,
	input wire logic ref_supply_out,
	input wire logic boot_ok,
	input wire logic fast_shutdown_trig
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ref_on_req: assert property (
		$rose(power_off_req_n) && system_reset_in_n |=> ref_supply_out) else $error("ref late");
	a_off_stays_off: assert property (
		!power_off_req_n && !ref_supply_out |=> !ref_supply_out) else $error("ref rose");
	a_boot_not_early: assert property (
		$rose(boot_ok) |-> $past(ref_supply_out, ACT - 1)) else $error("boot early");
	a_boot_with_ref: assert property (
		boot_ok |-> ref_supply_out) else $error("boot without ref");
	a_req_ends_boot: assert property (
		$fell(power_off_req_n) |=> !boot_ok) else $error("boot stuck");
	a_final_keeps_ref: assert property (
		$fell(power_off_req_n) && ref_supply_out |=> ref_supply_out [*3]) else $error("ref early");
	a_ref_drops: assert property (
		$fell(power_off_req_n) && ref_supply_out |-> ##[2:12] !ref_supply_out) else $error("ref stuck");
	// Host must not back-power the module through the trigger line
	a_trig_quiet_off: assert property (
		!ref_supply_out |-> !fast_shutdown_trig) else $error("trig high while off");
endmodule

// file: tb/tb_power_on_off_sequencer.sv
// Bench joining host and module ends of the sequencer
module tb_power_on_off_sequencer import pwrseq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_n = 0, ind = 0, fen = 0, on = 0, off = 0, rdy, act;
	logic [3:0] st;
	logic mrdy, moff, prm;
	int n_fail = 0, num_checks = 0;
	pwrseq_if p ();
	// Short counts keep the run brief
	pwrseq_module #(.ACT_CYC(20), .FIN_CYC(5)) pwrseq_module_inst (.mclk, .rst_n, .clk_en(1'b1),
		.pins(p), .shutdown_indication_enable(ind), .fast_shutdown_enable(fen),
		.cmd_port_ready(rdy), .fully_active(act), .state_out(st));
	pwrseq_host pwrseq_host_inst (.mclk, .rst_n, .clk_en(1'b1), .pins(p), .power_on_cmd(on),
		.fast_off_cmd(off), .use_boot_ok(ind), .module_ready(mrdy), .module_off(moff),
		.power_remove_ok(prm));
	pwrseq_monitor #(.ACT(20)) pwrseq_monitor_inst (.mclk, .rst_n,
		.power_off_req_n(p.power_off_req_n), .system_reset_in_n(p.system_reset_in_n),
		.ref_supply_out(p.ref_supply_out), .boot_ok(p.boot_ok),
		.fast_shutdown_trig(p.fast_shutdown_trig));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic power_up;
		on = 1;
		cyc(18);
		chk(st, PWRSEQ_INIT);
		chk({act, rdy}, 2'b01);
		cyc(10);
		chk({act, p.boot_ok}, {1'b1, ind});
		chk(mrdy, ind);
	endtask
	task automatic t_graceful;
		ind = 1;
		power_up();
		on = 0;
		cyc(2);
		chk({st, p.ref_supply_out}, {PWRSEQ_FINAL, 1'b1});
		cyc(8);
		chk(p.ref_supply_out, 0);
		chk({moff, prm}, 2'b11);
	endtask
	task automatic t_fast(input logic en);
		fen = en;
		ind = 0;
		power_up();
		off = 1;
		cyc(3);
		chk(st, en ? PWRSEQ_FINAL : PWRSEQ_ACTIVE);
		cyc(8);
		chk(p.ref_supply_out, !en);
		chk(moff, en);
		// Request still high: the module must not come back up by itself
		cyc(6);
		chk(st, en ? PWRSEQ_OFF : PWRSEQ_ACTIVE);
		on = 0;
		off = 0;
		cyc(10);
	endtask
	initial begin
		forever #5 mclk = ~mclk;
	end
	initial begin
		#20000;
		n_fail++;
		end_of_test();
	end
	initial begin
		cyc(10);
		rst_n = 1;
		t_graceful();
		t_fast(0);
		t_fast(1);
		end_of_test();
	end
endmodule
